// file: design/mlm_top.sv
// Motor load measurement: threshold, filter, load value, stall flag, registers
// How it works
// - Signed seven-bit threshold shifts the load value; negative is more sensitive.
// - Filter bit set averages four measurements; clear reports each threshold-corrected measurement.
// - Load value is ten-bit unsigned 0..1023; larger means lighter load.
// - Load value refreshes once per full step when filtering is off.
// - Value falls with load and clamps at zero at maximum load.
// - Stall output goes high when the load value reads zero.
// - Control words are twenty bits; the load value reads back in one.
module mlm_top #(
	parameter int unsigned THR_SHIFT = mlm_pkg::THR_SHIFT
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic full_step_i,
	input wire logic [mlm_pkg::LOAD_W-1:0] raw_measure_i,
	input wire logic [mlm_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [mlm_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [mlm_pkg::DATA_W-1:0] reg_rdata_o,
	output logic stall_flag_output_o,
	output logic irq_o
);
	logic [mlm_pkg::THR_W-1:0] load_sensitivity_threshold;
	logic [mlm_pkg::THR_W-1:0] next_threshold;
	logic load_filter_enable;
	logic next_filter_enable;
	logic [mlm_pkg::LOAD_W-1:0] load_value;
	logic [mlm_pkg::LOAD_W-1:0] next_load_value;
	logic stall;
	logic next_stall;
	logic [mlm_pkg::EV_W-1:0] int_status;
	logic [mlm_pkg::EV_W-1:0] next_int_status;
	logic [mlm_pkg::EV_W-1:0] int_enable;
	logic [mlm_pkg::EV_W-1:0] next_int_enable;
	logic [mlm_pkg::EV_W-1:0] events;
	logic [mlm_pkg::EV_W-1:0] clear_mask;
	logic [mlm_pkg::DATA_W-1:0] rdata;
	logic [mlm_pkg::DATA_W-1:0] next_rdata;
	logic signed [mlm_pkg::SUM_W-1:0] thr_ext;
	logic signed [mlm_pkg::SUM_W-1:0] offset;
	logic signed [mlm_pkg::SUM_W-1:0] sum;
	logic [mlm_pkg::LOAD_W-1:0] corrected;

	mlm_meas_if meas ();

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// One decode so the stall flag and the stall event never disagree
	function automatic logic load_is_zero(input logic [mlm_pkg::LOAD_W-1:0] v);
		return v == '0;
	endfunction : load_is_zero

	// ----------------------------------------
	// Threshold correction per full step
	// ----------------------------------------
	always_comb begin
		thr_ext = {{(mlm_pkg::SUM_W-mlm_pkg::THR_W){load_sensitivity_threshold[mlm_pkg::THR_W-1]}},
			load_sensitivity_threshold};
		offset = thr_ext <<< THR_SHIFT;
		sum = $signed({2'h0, raw_measure_i}) + offset;
		// Saturate instead of wrapping so heavy load never reads as light load
		if (sum[mlm_pkg::SUM_W-1]) begin
			corrected = '0;
		end else if (sum > $signed({2'h0, mlm_pkg::LOAD_MAX})) begin
			corrected = mlm_pkg::LOAD_MAX;
		end else begin
			corrected = sum[mlm_pkg::LOAD_W-1:0];
		end
	end

	assign meas.sample_valid = full_step_i;
	assign meas.sample = corrected;
	assign meas.filt_en = load_filter_enable;

	mlm_filter u_filter (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.m(meas.filter)
	);

	// ----------------------------------------
	// Load value, stall flag, events
	// ----------------------------------------
	always_comb begin
		next_load_value = load_value;
		next_stall = stall;
		events = '0;
		if (meas.result_valid) begin
			next_load_value = meas.result;
			next_stall = load_is_zero(meas.result);
			events[mlm_pkg::EV_NEW_BIT] = 1'b1;
			events[mlm_pkg::EV_STALL_BIT] = load_is_zero(meas.result) && !stall;
		end
	end

	// ----------------------------------------
	// Register port, twenty-bit words
	// ----------------------------------------
	always_comb begin
		next_threshold = load_sensitivity_threshold;
		next_filter_enable = load_filter_enable;
		next_int_enable = int_enable;
		clear_mask = '0;
		if (reg_wr_i) begin
			if (reg_addr_i == mlm_pkg::OFS_CONFIG) begin
				next_threshold = reg_wdata_i[mlm_pkg::CFG_THR_LSB +: mlm_pkg::THR_W];
				next_filter_enable = reg_wdata_i[mlm_pkg::CFG_FILT_BIT];
			end else if (reg_addr_i == mlm_pkg::OFS_INT_CLEAR) begin
				clear_mask = reg_wdata_i[mlm_pkg::EV_W-1:0];
			end else if (reg_addr_i == mlm_pkg::OFS_INT_ENABLE) begin
				next_int_enable = reg_wdata_i[mlm_pkg::EV_W-1:0];
			end
		end
		// New events win over a clear in the same cycle
		next_int_status = (int_status & ~clear_mask) | events;
		next_rdata = '0;
		if (reg_rd_i) begin
			if (reg_addr_i == mlm_pkg::OFS_CONFIG) begin
				next_rdata[mlm_pkg::CFG_THR_LSB +: mlm_pkg::THR_W] = load_sensitivity_threshold;
				next_rdata[mlm_pkg::CFG_FILT_BIT] = load_filter_enable;
			end else if (reg_addr_i == mlm_pkg::OFS_LOAD) begin
				next_rdata[mlm_pkg::LOAD_W-1:0] = load_value;
				next_rdata[mlm_pkg::LOAD_STALL_BIT] = stall;
			end else if (reg_addr_i == mlm_pkg::OFS_INT_STATUS) begin
				next_rdata[mlm_pkg::EV_W-1:0] = int_status;
			end else if (reg_addr_i == mlm_pkg::OFS_INT_ENABLE) begin
				next_rdata[mlm_pkg::EV_W-1:0] = int_enable;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			load_sensitivity_threshold <= mlm_pkg::RST_THR;
			load_filter_enable <= mlm_pkg::RST_FILT;
			load_value <= mlm_pkg::RST_LOAD;
			stall <= 1'b0;
			int_status <= '0;
			int_enable <= '0;
			rdata <= '0;
		end else begin
			load_sensitivity_threshold <= next_threshold;
			load_filter_enable <= next_filter_enable;
			load_value <= next_load_value;
			stall <= next_stall;
			int_status <= next_int_status;
			int_enable <= next_int_enable;
			rdata <= next_rdata;
		end
	end

	assign reg_rdata_o = rdata;
	assign stall_flag_output_o = stall;
	assign irq_o = |(int_status & int_enable);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_THRESHOLD_SIGN: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		full_step_i && load_sensitivity_threshold[mlm_pkg::THR_W-1] |-> corrected <= raw_measure_i)
		else $error("Negative threshold not sign-extended");
	AST_CLAMP_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		full_step_i && sum < 0 |-> corrected == '0)
		else $error("Load value not clamped at zero");
	AST_CLAMP_TOP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		full_step_i && sum > $signed({2'h0, mlm_pkg::LOAD_MAX}) |-> corrected == mlm_pkg::LOAD_MAX)
		else $error("Load value not clamped at 1023");
	AST_STEP_REFRESH: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		full_step_i && !load_filter_enable && !reg_wr_i |-> ##2 load_value == $past(corrected, 2))
		else $error("Load value not refreshed after full step");
	AST_STALL_OUT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		meas.result_valid |=> stall_flag_output_o == load_is_zero($past(meas.result)))
		else $error("Stall output does not follow zero load value");
	AST_STALL_EVENT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		meas.result_valid && load_is_zero(meas.result) && !stall |=> int_status[mlm_pkg::EV_STALL_BIT])
		else $error("Stall entry event not recorded");
	AST_LOAD_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!meas.result_valid |=> $stable(load_value) && $stable(stall_flag_output_o))
		else $error("Load value changed without a new measurement");
	AST_READBACK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		reg_rd_i && reg_addr_i == mlm_pkg::OFS_LOAD |=> reg_rdata_o[mlm_pkg::LOAD_W-1:0] == $past(load_value))
		else $error("Load value read back wrong");
	AST_EVENT_WINS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		meas.result_valid |=> int_status[mlm_pkg::EV_NEW_BIT] && (irq_o == int_enable[mlm_pkg::EV_NEW_BIT] || int_status[1]))
		else $error("Event lost against clear");
	AST_IRQ_NEW: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		meas.result_valid && int_enable[mlm_pkg::EV_NEW_BIT] && !reg_wr_i |=> irq_o)
		else $error("Enabled new value event raised no interrupt");

	// ----------------------------------------
	// Register port checks
	// ----------------------------------------
	AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!reg_rd_i |=> reg_rdata_o == '0)
		else $error("Read data present without a read");
	AST_CLEAR_READ_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		reg_rd_i && reg_addr_i == mlm_pkg::OFS_INT_CLEAR |=> reg_rdata_o == '0)
		else $error("Clear register reads nonzero");
	AST_CLEAR_BITS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		reg_wr_i && reg_addr_i == mlm_pkg::OFS_INT_CLEAR && !meas.result_valid
		|=> (int_status & $past(reg_wdata_i[mlm_pkg::EV_W-1:0])) == '0)
		else $error("Status bit survived its clear");
	AST_UNMAPPED_WRITE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		reg_wr_i && reg_addr_i > mlm_pkg::OFS_INT_ENABLE
		|=> $stable(load_sensitivity_threshold) && $stable(load_filter_enable) && $stable(int_enable))
		else $error("Write to unmapped index changed a register");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	COV_STALL: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(stall_flag_output_o));
	COV_IRQ: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(irq_o));
	COV_NEG_THR: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		full_step_i && load_sensitivity_threshold[mlm_pkg::THR_W-1]);
	COV_SET_AND_CLEAR: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		meas.result_valid && reg_wr_i && reg_addr_i == mlm_pkg::OFS_INT_CLEAR);
endmodule : mlm_top

// file: design/mlm_pkg.sv
// Constants shared by the motor load measurement block
package mlm_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 20;
	localparam int unsigned LOAD_W = 10;
	localparam int unsigned THR_W = 7;
	localparam int unsigned SUM_W = 12;
	localparam int unsigned EV_W = 2;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_LOAD = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_INT_CLEAR = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 3'h4;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned CFG_THR_LSB = 0;
	localparam int unsigned CFG_FILT_BIT = 8;
	localparam int unsigned LOAD_STALL_BIT = 16;
	localparam int unsigned EV_NEW_BIT = 0;
	localparam int unsigned EV_STALL_BIT = 1;
	// ----------------------------------------
	// Reset values and arithmetic
	// ----------------------------------------
	localparam logic [THR_W-1:0] RST_THR = 7'h00;
	localparam logic RST_FILT = 1'b0;
	localparam logic [LOAD_W-1:0] RST_LOAD = 10'h3FF;
	localparam logic [LOAD_W-1:0] LOAD_MAX = 10'h3FF;
	localparam int unsigned THR_SHIFT = 3;
	localparam logic [1:0] FILT_LAST = 2'h3;
	localparam int unsigned FILT_SHIFT = 2;
endpackage : mlm_pkg

// file: design/mlm_meas_if.sv
// Carrier between load path and averaging filter
interface mlm_meas_if;
	logic sample_valid;
	logic [mlm_pkg::LOAD_W-1:0] sample;
	logic filt_en;
	logic result_valid;
	logic [mlm_pkg::LOAD_W-1:0] result;
	modport producer (output sample_valid, output sample, output filt_en, input result_valid, input result);
	modport filter (input sample_valid, input sample, input filt_en, output result_valid, output result);
endinterface : mlm_meas_if

// file: design/mlm_filter.sv
// Four-step averaging filter with bypass
module mlm_filter (
	input wire logic clk_i,
	input wire logic reset_n_i,
	mlm_meas_if.filter m
);
	logic [1:0] count;
	logic [1:0] next_count;
	logic [mlm_pkg::SUM_W-1:0] sum;
	logic [mlm_pkg::SUM_W-1:0] next_sum;
	logic [mlm_pkg::SUM_W-1:0] acc;
	logic valid;
	logic next_valid;
	logic [mlm_pkg::LOAD_W-1:0] result;
	logic [mlm_pkg::LOAD_W-1:0] next_result;

	// ----------------------------------------
	// Accumulate or bypass
	// ----------------------------------------
	always_comb begin
		acc = sum + {2'h0, m.sample};
		next_count = count;
		next_sum = sum;
		next_valid = 1'b0;
		next_result = result;
		if (!m.filt_en) begin
			// Restart block so the first filtered result has four fresh samples
			next_count = 2'h0;
			next_sum = '0;
			if (m.sample_valid) begin
				next_result = m.sample;
				next_valid = 1'b1;
			end
		end else if (m.sample_valid) begin
			if (count == mlm_pkg::FILT_LAST) begin
				next_result = acc[mlm_pkg::FILT_SHIFT +: mlm_pkg::LOAD_W];
				next_valid = 1'b1;
				next_count = 2'h0;
				next_sum = '0;
			end else begin
				next_count = count + 2'h1;
				next_sum = acc;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count <= 2'h0;
			sum <= '0;
			valid <= 1'b0;
			result <= mlm_pkg::RST_LOAD;
		end else begin
			count <= next_count;
			sum <= next_sum;
			valid <= next_valid;
			result <= next_result;
		end
	end

	assign m.result_valid = valid;
	assign m.result = result;

	// ----------------------------------------
	// Check history of the last three samples
	// ----------------------------------------
	// Kept apart from the accumulator so the mean check does not reuse it
	logic [mlm_pkg::LOAD_W-1:0] hist [3];
	logic [mlm_pkg::LOAD_W-1:0] next_hist [3];
	logic [mlm_pkg::SUM_W-1:0] hist_sum;

	always_comb begin
		next_hist = hist;
		if (m.sample_valid) begin
			next_hist[0] = m.sample;
			next_hist[1] = hist[0];
			next_hist[2] = hist[1];
		end
		hist_sum = {2'h0, hist[0]} + {2'h0, hist[1]} + {2'h0, hist[2]} + {2'h0, m.sample};
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hist <= '{default: '0};
		end else begin
			hist <= next_hist;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_UNFILTERED_PASS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		m.sample_valid && !m.filt_en |=> m.result_valid && m.result == $past(m.sample))
		else $error("Unfiltered sample not passed through");
	AST_FILTER_RATE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		m.sample_valid && m.filt_en && count != mlm_pkg::FILT_LAST |=> !m.result_valid)
		else $error("Filtered result before fourth step");
	AST_FILTER_MEAN: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		m.sample_valid && m.filt_en && count == mlm_pkg::FILT_LAST
		|=> m.result_valid && m.result == $past(hist_sum[mlm_pkg::FILT_SHIFT +: mlm_pkg::LOAD_W]))
		else $error("Filtered result is not the mean of four");
	COV_FILTERED: cover property (@(posedge clk_i) disable iff (!reset_n_i) m.filt_en && m.result_valid);
endmodule : mlm_filter

// file: sim/mlm_host_model.sv
// Host-side model: programs and reads the load measurement registers
module mlm_host_model (
	input wire logic clk_i,
	output logic [mlm_pkg::ADDR_W-1:0] reg_addr_o,
	output logic [mlm_pkg::DATA_W-1:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	input wire logic [mlm_pkg::DATA_W-1:0] reg_rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr_o = 3'h0;
		reg_wdata_o = 20'h00000;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// One 20-bit word per access
	task automatic wr(input logic [mlm_pkg::ADDR_W-1:0] a, input logic [mlm_pkg::DATA_W-1:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~d;
	endtask : wr
	task automatic rd(input logic [mlm_pkg::ADDR_W-1:0] a, output logic [mlm_pkg::DATA_W-1:0] d);
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		@(posedge clk_i);
		d = reg_rdata_i;
	endtask : rd
	// ----------------------------------------
	// Tuning policy
	// ----------------------------------------
	// Settings below ten only when a scenario asks for them
	// Tuning starts at zero
	task automatic set_cfg(input logic [6:0] thr, input logic filt);
		wr(mlm_pkg::OFS_CONFIG, {11'h000, filt, 1'b0, thr});
	endtask : set_cfg
	// Early stall lowers, early zero raises
	function automatic logic [6:0] tune_thr(input logic stall_early, input logic zero_early, input logic [6:0] t);
		return stall_early ? t - 7'h01 : (zero_early ? t + 7'h01 : t);
	endfunction : tune_thr
endmodule : mlm_host_model

// file: sim/mlm_top_tb_top.sv
// Self-checking bench for the motor load measurement block
module mlm_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic full_step_i = 1'b0;
	logic [mlm_pkg::LOAD_W-1:0] raw_measure_i = 10'h000;
	logic [mlm_pkg::ADDR_W-1:0] reg_addr_i;
	logic [mlm_pkg::DATA_W-1:0] reg_wdata_i;
	logic [mlm_pkg::DATA_W-1:0] reg_rdata_o;
	logic reg_wr_i;
	logic reg_rd_i;
	logic stall_flag_output_o;
	logic irq_o;
	int errors = 0;
	int tests_run = 0;
	always #50 clk_i = ~clk_i;
	mlm_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .full_step_i(full_step_i), .raw_measure_i(raw_measure_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .stall_flag_output_o(stall_flag_output_o), .irq_o(irq_o));
	mlm_host_model i_host (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic rd_chk(input logic [2:0] a, input logic [19:0] exp, input string name);
		logic [19:0] d;
		i_host.rd(a, d);
		check(name, d, exp);
	endtask : rd_chk
	// Result lands two edges after the step is taken
	task automatic step(input logic [9:0] v);
		@(posedge clk_i);
		full_step_i <= 1'b1;
		raw_measure_i <= v;
		@(posedge clk_i);
		full_step_i <= 1'b0;
		raw_measure_i <= ~v;
		repeat (2) @(posedge clk_i);
		#1;
	endtask : step
	function automatic logic [19:0] exp_load(input logic [6:0] thr, input int raw);
		int v;
		v = raw + $signed(thr) * (1 << mlm_pkg::THR_SHIFT);
		v = v < 0 ? 0 : (v > 1023 ? 1023 : v);
		return {3'h0, v == 0, 6'h00, v[9:0]};
	endfunction : exp_load
	task automatic end_sim();
		$display("Checks run %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		check("stall", {19'h0, stall_flag_output_o}, 20'h00000);
		rd_chk(mlm_pkg::OFS_CONFIG, 20'h00000, "config");
		rd_chk(mlm_pkg::OFS_LOAD, 20'h003FF, "load");
		i_host.wr(3'h5, 20'hFFFFF);
		rd_chk(3'h5, 20'h00000, "unmapped");
	endtask : t_reset
	task automatic t_unfilt();
		i_host.wr(mlm_pkg::OFS_INT_ENABLE, 20'h00003);
		step(10'h1F4);
		check("irq", {19'h0, irq_o}, 20'h00001);
		rd_chk(mlm_pkg::OFS_LOAD, 20'h001F4, "load");
		rd_chk(mlm_pkg::OFS_INT_STATUS, 20'h00001, "status");
		i_host.wr(mlm_pkg::OFS_INT_CLEAR, 20'h00001);
		#1;
		check("irq", {19'h0, irq_o}, 20'h00000);
		step(10'h3FF);
		rd_chk(mlm_pkg::OFS_LOAD, 20'h003FF, "load");
	endtask : t_unfilt
	// Extreme settings, a clamp at either end and a stall
	task automatic t_thr();
		logic [6:0] thr [4] = '{7'h7F, 7'h3F, 7'h40, 7'h00};
		int raw [4] = '{500, 1000, 300, 500};
		logic [19:0] e;
		for (int i = 0; i < 4; i++) begin
			i_host.set_cfg(thr[i], 1'b0);
			step(raw[i][9:0]);
			e = exp_load(thr[i], raw[i]);
			check("stall", {19'h0, stall_flag_output_o}, {19'h0, e[16]});
			rd_chk(mlm_pkg::OFS_LOAD, e, "load");
			if (i == 2) begin
				rd_chk(mlm_pkg::OFS_INT_STATUS, 20'h00003, "status");
			end
		end
	endtask : t_thr
	task automatic t_filt();
		i_host.set_cfg(i_host.tune_thr(1'b0, 1'b0, 7'h00), 1'b1);
		step(10'h064);
		step(10'h0C8);
		step(10'h12C);
		rd_chk(mlm_pkg::OFS_LOAD, 20'h001F4, "load");
		step(10'h190);
		rd_chk(mlm_pkg::OFS_LOAD, 20'h000FA, "load");
		i_host.set_cfg(7'h00, 1'b0);
		step(10'h008);
		rd_chk(mlm_pkg::OFS_LOAD, 20'h00008, "load");
	endtask : t_filt
	task automatic t_mask();
		i_host.wr(mlm_pkg::OFS_INT_ENABLE, 20'h00000);
		i_host.wr(mlm_pkg::OFS_INT_CLEAR, 20'h00003);
		step(10'h258);
		check("irq", {19'h0, irq_o}, 20'h00000);
		rd_chk(mlm_pkg::OFS_INT_STATUS, 20'h00001, "status");
		rd_chk(mlm_pkg::OFS_INT_ENABLE, 20'h00000, "enable");
		rd_chk(mlm_pkg::OFS_INT_CLEAR, 20'h00000, "clear");
	endtask : t_mask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_unfilt();
		t_thr();
		t_filt();
		t_mask();
		end_sim();
	end
	// Whole run is well under a thousand cycles
	initial begin
		#1000000;
		errors++;
		end_sim();
	end
endmodule : mlm_top_tb_top
